// *** dtx_params.svh ***
// Purpose: register indices, reset values and field positions of the transmit channel
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef DTX_PARAMS_SVH
`define DTX_PARAMS_SVH

`define DTX_IDX_CTL    12'hfb8
`define DTX_IDX_IO     12'hfb9
`define DTX_IDX_HI     12'hfba
`define DTX_IDX_START  12'hfbb
`define DTX_IDX_END    12'hfbc
`define DTX_IDX_CONV   12'hfbd
`define DTX_IDX_IRQ    12'hfc6
`define DTX_IDX_MASK   12'hfd0

`define DTX_REG_RST    8'h00
`define DTX_IRQ_BIT    4
`define DTX_HI_START   3:0
`define DTX_HI_END     7:4
`define DTX_PAGE       4'hf
`define DTX_TRIG_RSVD  3'h7

`endif

// *** dtx_pkg.sv ***
// Purpose: types shared by the transmit channel
// Assumes: nothing beyond SystemVerilog packed types
// Notes:   control struct is laid out from bit 7 down to bit 0
`default_nettype none
package dtx_pkg;

  typedef enum logic [1:0] {DTX_IDLE, DTX_RD, DTX_WR} dtx_state_e;

  typedef struct packed {
    logic       en;
    logic       loop;
    logic       dir;
    logic       ie;
    logic       wsel;
    logic [2:0] trig;
  } dtx_ctl_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } dtx_bus_s;

  typedef struct packed {
    logic [3:0] timer;
    logic       uart0Empty;
    logic       uart1Empty;
    logic       i2cEmpty;
  } dtx_trig_s;

  typedef struct packed {
    dtx_state_e  st;
    dtx_ctl_s    ctl;
    logic [7:0]  io;
    logic [7:0]  hi;
    logic [7:0]  startLo;
    logic [7:0]  endLo;
    logic [7:0]  conv;
    logic [11:0] cur;
    logic        second;
    logic        armed;
    logic        flag;
    logic        mask;
    logic        irq;
    dtx_bus_s    bus;
    logic [31:0] rdata;
  } dtx_regs_s;

endpackage
`default_nettype wire

// *** dtx_tx_channel.sv ***
// Purpose: one transmit DMA channel with its APB register slave and request flag
// Assumes: triggers and bus answers come from logic on clk_sys; busAck is a one-cycle pulse
// Notes:   each byte is a read phase then a write phase on one shared 12-bit bus
`default_nettype none
`include "dtx_params.svh"

module dtx_tx_channel
  import dtx_pkg::*;
#(
  parameter int AW = 14
) (
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire dtx_trig_s     trig,
  input  wire logic          irqGlobalEn,
  output dtx_bus_s           bus,
  input  wire logic          busAck,
  input  wire logic [7:0]    busRdata,
  output logic               irq
);

  dtx_regs_s s;
  dtx_regs_s next_s;

  function automatic logic trigLevel(input logic [2:0] code, input dtx_trig_s t);
    logic lvl;
    lvl = 1'b0;
    unique case (code)
      3'h0, 3'h1, 3'h2, 3'h3: lvl = t.timer[code[1:0]];
      3'h4: lvl = t.uart0Empty;
      3'h5: lvl = t.uart1Empty;
      3'h6: lvl = t.i2cEmpty;
      `DTX_TRIG_RSVD: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  function automatic logic isReg(input logic [AW-1:0] a, input logic [11:0] idx);
    return a == AW'({idx, 2'b00});
  endfunction

  logic        lvl;
  logic        req;
  logic        done;
  logic        byteDone;
  logic        atEnd;
  logic        setup;
  logic        wrEn;
  logic        hit;
  logic        clrFlag;
  logic        swCtl;
  logic [11:0] startAddr;
  logic [11:0] endAddr;
  logic [11:0] ioAddr;
  logic [11:0] ioNext;
  logic [7:0]  rd;

  assign prdata = s.rdata;
  assign bus    = s.bus;
  assign irq    = s.irq;
  assign pready = 1'b1;

  always_comb begin
    next_s    = s;
    done      = 1'b0;
    byteDone  = 1'b0;
    rd        = 8'h00;
    lvl       = trigLevel(s.ctl.trig, trig);
    req       = s.ctl.en && lvl && s.armed;
    startAddr = {s.hi[`DTX_HI_START], s.startLo};
    endAddr   = {s.hi[`DTX_HI_END], s.endLo};
    ioAddr    = {`DTX_PAGE, s.io};
    ioNext    = {`DTX_PAGE, s.io + 8'h01};
    atEnd     = s.cur == endAddr;
    setup     = psel && !penable;
    wrEn      = psel && penable && pwrite;
    hit       = isReg(paddr, `DTX_IDX_CTL) || isReg(paddr, `DTX_IDX_IO) ||
                isReg(paddr, `DTX_IDX_HI) || isReg(paddr, `DTX_IDX_START) ||
                isReg(paddr, `DTX_IDX_END) || isReg(paddr, `DTX_IDX_CONV) ||
                isReg(paddr, `DTX_IDX_IRQ) || isReg(paddr, `DTX_IDX_MASK);
    pslverr   = psel && penable && !hit;
    clrFlag   = wrEn && isReg(paddr, `DTX_IDX_IRQ) && pwdata[`DTX_IRQ_BIT];
    swCtl     = wrEn && isReg(paddr, `DTX_IDX_CTL);

    // re-arm only once the selected trigger has dropped
    if (!lvl) begin
      next_s.armed = 1'b1;
    end

    unique case (s.st)
      DTX_IDLE: begin
        if (req) begin
          next_s.armed    = 1'b0;
          next_s.second   = 1'b0;
          next_s.st       = DTX_RD;
          next_s.bus.req  = 1'b1;
          next_s.bus.we   = 1'b0;
          next_s.bus.addr = s.ctl.dir ? ioAddr : s.cur;
        end
      end
      DTX_RD: begin
        if (busAck) begin
          next_s.st        = DTX_WR;
          next_s.bus.we    = 1'b1;
          next_s.bus.wdata = busRdata;
          next_s.bus.addr  = s.ctl.dir ? s.cur : (s.second ? ioNext : ioAddr);
        end
      end
      DTX_WR: begin
        if (busAck) begin
          byteDone       = 1'b1;
          next_s.st      = DTX_IDLE;
          next_s.bus.req = 1'b0;
          next_s.bus.we  = 1'b0;
          if (atEnd) begin
            done       = 1'b1;
            next_s.cur = startAddr;
            if (!s.ctl.loop) begin
              next_s.ctl.en = 1'b0;
            end
          end else begin
            next_s.cur = s.cur + 12'h001;
            // second byte of a word request, unless software disabled the channel
            if (s.ctl.wsel && !s.second && s.ctl.en) begin
              next_s.second   = 1'b1;
              next_s.st       = DTX_RD;
              next_s.bus.req  = 1'b1;
              next_s.bus.addr = s.ctl.dir ? ioNext : s.cur + 12'h001;
            end
          end
        end
      end
    endcase

    // set wins over a simultaneous write-one clear
    next_s.flag = (done && s.ctl.ie) || (s.flag && !clrFlag);
    next_s.irq  = next_s.flag && s.mask && irqGlobalEn;

    unique case (1'b1)
      isReg(paddr, `DTX_IDX_CTL):   rd = s.ctl;
      isReg(paddr, `DTX_IDX_IO):    rd = s.io;
      isReg(paddr, `DTX_IDX_HI):    rd = s.hi;
      isReg(paddr, `DTX_IDX_START): rd = s.cur[7:0];
      isReg(paddr, `DTX_IDX_END):   rd = s.endLo;
      isReg(paddr, `DTX_IDX_CONV):  rd = s.conv;
      isReg(paddr, `DTX_IDX_IRQ):   rd = {3'h0, s.flag, 4'h0};
      isReg(paddr, `DTX_IDX_MASK):  rd = {3'h0, s.mask, 4'h0};
      default:                      rd = 8'h00;
    endcase
    if (setup && !pwrite) begin
      next_s.rdata = {24'h000000, rd};
    end

    // software writes come last and win over engine updates
    if (wrEn) begin
      if (isReg(paddr, `DTX_IDX_CTL)) begin
        next_s.ctl = pwdata[7:0];
      end
      if (isReg(paddr, `DTX_IDX_IO)) begin
        next_s.io = pwdata[7:0];
      end
      if (isReg(paddr, `DTX_IDX_HI)) begin
        next_s.hi        = pwdata[7:0];
        next_s.cur[11:8] = pwdata[3:0];
      end
      if (isReg(paddr, `DTX_IDX_START)) begin
        next_s.startLo  = pwdata[7:0];
        next_s.cur[7:0] = pwdata[7:0];
      end
      if (isReg(paddr, `DTX_IDX_END)) begin
        next_s.endLo = pwdata[7:0];
      end
      if (isReg(paddr, `DTX_IDX_CONV)) begin
        next_s.conv = pwdata[7:0];
      end
      if (isReg(paddr, `DTX_IDX_MASK)) begin
        next_s.mask = pwdata[`DTX_IRQ_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s       <= '0;
      s.ctl   <= `DTX_REG_RST;
      s.armed <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  property p_idle_disabled;
    s.st == DTX_IDLE && !s.ctl.en |=> s.st == DTX_IDLE && !s.bus.req;
  endproperty
  a_idle_disabled: assert property (p_idle_disabled) else $error("channel left idle while disabled");

  property p_rsvd_trig;
    s.st == DTX_IDLE && s.ctl.trig == `DTX_TRIG_RSVD |=> s.st == DTX_IDLE;
  endproperty
  a_rsvd_trig: assert property (p_rsvd_trig) else $error("reserved trigger started a transfer");

  property p_once_per_assert;
    s.st == DTX_IDLE && !s.armed |=> s.st == DTX_IDLE;
  endproperty
  a_once_per_assert: assert property (p_once_per_assert) else $error("second service within one trigger");

  property p_dir_mem_rd;
    s.st == DTX_RD && !s.ctl.dir && !s.second |-> s.bus.addr == s.cur && !s.bus.we;
  endproperty
  a_dir_mem_rd: assert property (p_dir_mem_rd) else $error("memory read address wrong");

  property p_dir_per_rd;
    s.st == DTX_RD && s.ctl.dir && !s.second |-> s.bus.addr == {`DTX_PAGE, s.io};
  endproperty
  a_dir_per_rd: assert property (p_dir_per_rd) else $error("peripheral read address wrong");

  property p_data_copy;
    s.st == DTX_RD && busAck |=> s.bus.we && s.bus.wdata == $past(busRdata);
  endproperty
  a_data_copy: assert property (p_data_copy) else $error("written byte differs from read byte");

  property p_ie_flag;
    done && s.ctl.ie |=> s.flag [*2];
  endproperty
  a_ie_flag: assert property (p_ie_flag) else $error("end transfer did not raise the flag");

  property p_flag_cause;
    $rose(s.flag) |-> $past(done && s.ctl.ie);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag rose without enabled end transfer");

  property p_stop;
    done && !s.ctl.loop && !swCtl |=> !s.ctl.en && s.st == DTX_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("channel still enabled after end");

  property p_loop;
    done && s.ctl.loop && !swCtl && !wrEn |=> s.ctl.en && s.cur == startAddr;
  endproperty
  a_loop: assert property (p_loop) else $error("loop did not reload start");

  property p_incr;
    byteDone && !atEnd && !wrEn |=> s.cur == $past(s.cur) + 12'h001;
  endproperty
  a_incr: assert property (p_incr) else $error("address not advanced by one");

  property p_word;
    byteDone && !atEnd && s.ctl.wsel && s.ctl.en && !s.second |=> s.st == DTX_RD && s.second;
  endproperty
  a_word: assert property (p_word) else $error("second byte of word not started");

  property p_sticky;
    s.flag && !clrFlag |=> s.flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");

  property p_irq_out;
    s.flag && s.mask && irqGlobalEn ##1 s.flag && s.mask && irqGlobalEn |-> irq;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("pending enabled flag not passed on");

  property p_trig_timer;
    s.st == DTX_IDLE && s.ctl.en && s.armed && !s.ctl.trig[2] && trig.timer[s.ctl.trig[1:0]] |=> s.st == DTX_RD;
  endproperty
  a_trig_timer: assert property (p_trig_timer) else $error("timer trigger not served");

  property p_trig_uart0;
    s.st == DTX_IDLE && s.ctl.en && s.armed && s.ctl.trig == 3'h4 && trig.uart0Empty |=> s.st == DTX_RD;
  endproperty
  a_trig_uart0: assert property (p_trig_uart0) else $error("first serial trigger not served");

  property p_trig_uart1;
    s.st == DTX_IDLE && s.ctl.en && s.armed && s.ctl.trig == 3'h5 && trig.uart1Empty |=> s.st == DTX_RD;
  endproperty
  a_trig_uart1: assert property (p_trig_uart1) else $error("second serial trigger not served");

  property p_trig_i2c;
    s.st == DTX_IDLE && s.ctl.en && s.armed && s.ctl.trig == 3'h6 && trig.i2cEmpty |=> s.st == DTX_RD;
  endproperty
  a_trig_i2c: assert property (p_trig_i2c) else $error("two-wire trigger not served");

  property p_single_byte;
    byteDone && !s.ctl.wsel |=> s.st == DTX_IDLE && !s.bus.req;
  endproperty
  a_single_byte: assert property (p_single_byte) else $error("byte mode moved more than one byte");

  property p_word_last;
    byteDone && s.second |=> s.st == DTX_IDLE;
  endproperty
  a_word_last: assert property (p_word_last) else $error("word mode moved a third byte");

  property p_ie_off;
    done && !s.ctl.ie && !s.flag |=> !s.flag;
  endproperty
  a_ie_off: assert property (p_ie_off) else $error("flag raised with interrupt disabled");

  property p_dir_mem_wr;
    s.st == DTX_RD && busAck && !s.ctl.dir && !s.second |=> s.bus.addr == {`DTX_PAGE, $past(s.io)};
  endproperty
  a_dir_mem_wr: assert property (p_dir_mem_wr) else $error("peripheral write address wrong");

  property p_dir_per_wr;
    s.st == DTX_RD && busAck && s.ctl.dir |=> s.bus.addr == $past(s.cur);
  endproperty
  a_dir_per_wr: assert property (p_dir_per_wr) else $error("memory write address wrong");

  property p_start_hi;
    wrEn && isReg(paddr, `DTX_IDX_HI) |=> s.cur[11:8] == $past(pwdata[3:0]);
  endproperty
  a_start_hi: assert property (p_start_hi) else $error("start high nibble not loaded");

  property p_end_hi;
    wrEn && isReg(paddr, `DTX_IDX_HI) |=> endAddr[11:8] == $past(pwdata[7:4]);
  endproperty
  a_end_hi: assert property (p_end_hi) else $error("end high nibble not loaded");

  property p_end_lo;
    wrEn && isReg(paddr, `DTX_IDX_END) |=> endAddr[7:0] == $past(pwdata[7:0]);
  endproperty
  a_end_lo: assert property (p_end_lo) else $error("end low byte not loaded");

  property p_start_lo;
    wrEn && isReg(paddr, `DTX_IDX_START) |=> s.cur[7:0] == $past(pwdata[7:0]);
  endproperty
  a_start_lo: assert property (p_start_lo) else $error("start low byte not loaded");

  property p_cur_read;
    setup && !pwrite && isReg(paddr, `DTX_IDX_START) |=> prdata[7:0] == $past(s.cur[7:0]);
  endproperty
  a_cur_read: assert property (p_cur_read) else $error("start register does not read current address");

  property p_page_word;
    s.st == DTX_RD && busAck && !s.ctl.dir && s.second |=> s.bus.addr == {`DTX_PAGE, $past(s.io) + 8'h01};
  endproperty
  a_page_word: assert property (p_page_word) else $error("second peripheral address wrong");

  property p_flag_read;
    setup && !pwrite && isReg(paddr, `DTX_IDX_IRQ) |=> prdata[`DTX_IRQ_BIT] == $past(s.flag);
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("request flag not readable");

  property p_clear;
    clrFlag && !(done && s.ctl.ie) |=> !s.flag;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared by write of one");

  property p_irq_off;
    !irqGlobalEn |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt passed on while globally disabled");

endmodule
`default_nettype wire

// *** dtx_mem_model.sv ***
// Purpose: far-side model of register-file memory and peripheral page for the engine bus
// Assumes: bus holds its request until the busAck edge
// Notes:   slow adds three wait cycles per phase; read data is scrambled outside the ack cycle
`default_nettype none
module dtx_mem_model
  import dtx_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     slow,
  input  wire dtx_bus_s bus,
  output logic          busAck,
  output logic [7:0]    busRdata
);
  logic [7:0] mem [0:4095];
  logic [1:0] waitCnt;

  initial begin
    busAck = 1'b0;
    busRdata = 8'h00;
    waitCnt = 2'h0;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end

  // a phase is answered once; the design moves on at the ack edge
  always @(posedge clk_sys) begin
    busAck <= 1'b0;
    busRdata <= ~busRdata;
    if (bus.req && !busAck) begin
      if (slow && waitCnt != 2'h3) begin
        waitCnt <= waitCnt + 2'h1;
      end else begin
        waitCnt <= 2'h0;
        busAck <= 1'b1;
        if (bus.we) begin
          mem[bus.addr] <= bus.wdata;
        end else begin
          busRdata <= mem[bus.addr];
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** dtx_tx_channel_tb_top.sv ***
// Purpose: self-checking bench for the transmit DMA channel
// Assumes: memory model holds byte i as i xor 5a at start
// Notes:   table rows first, then refusal and a reset of the disabled, idle channel
`default_nettype none
`include "dtx_params.svh"
module dtx_tx_channel_tb_top
  import dtx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  ctl;
    logic [11:0] st;
    logic [7:0]  endLo;
    logic [3:0]  endHi;
    logic        ge;
    logic        msk;
  } dtx_row_s;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  dtx_trig_s   trig = '0;
  logic        irqGlobalEn = 1'b0;
  dtx_bus_s    bus;
  logic        busAck;
  logic [7:0]  busRdata;
  logic        irq;
  logic        slow = 1'b0;
  logic [31:0] rd;
  logic        err;
  logic [11:0] lastA = '0;
  logic [7:0]  lastD = '0;
  int          wrCnt = 0;
  int          num_errors = 0;
  int          compares = 0;
  dtx_row_s    rows [9] = '{'{8'h90, 12'h120, 8'h20, 4'h1, 1'b1, 1'b1}, '{8'hd9, 12'h230, 8'h31, 4'h2, 1'b1, 1'b1},
    '{8'ha2, 12'h340, 8'h50, 4'h3, 1'b1, 1'b1}, '{8'hab, 12'h3fe, 8'hff, 4'h3, 1'b1, 1'b1},
    '{8'h94, 12'h500, 8'h00, 4'h6, 1'b1, 1'b1}, '{8'h95, 12'h600, 8'h00, 4'h6, 1'b0, 1'b1},
    '{8'h96, 12'h700, 8'h00, 4'h7, 1'b1, 1'b0}, '{8'h97, 12'h800, 8'h00, 4'h8, 1'b1, 1'b1},
    '{8'h10, 12'h900, 8'h00, 4'h9, 1'b1, 1'b1}};

  dtx_tx_channel dtx_tx_channel_inst (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig(trig), .irqGlobalEn(irqGlobalEn), .bus(bus), .busAck(busAck), .busRdata(busRdata), .irq(irq));
  dtx_mem_model dtx_mem_model_inst (.clk_sys(clk_sys), .slow(slow), .bus(bus), .busAck(busAck),
    .busRdata(busRdata));

  always #5 clk_sys = ~clk_sys;

  // records each completed write phase of the engine bus
  always @(posedge clk_sys) begin
    if (bus.req && busAck && bus.we) begin
      wrCnt <= wrCnt + 1;
      lastA <= bus.addr;
      lastD <= bus.wdata;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #50000;
    num_errors++;
    final_report;
  end

  initial begin
    dtx_row_s    r;
    logic [11:0] a;
    logic [7:0]  io;
    logic        done;
    int          n;
    int          expN;
    int          base;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      r = rows[i];
      n = r.ctl[3] ? 2 : 1;
      io = {4'(i), 4'h8};
      a = r.st + 12'(n - 1);
      expN = (r.ctl[7] && r.ctl[2:0] != `DTX_TRIG_RSVD) ? n : 0;
      done = ({r.endHi, r.endLo} == a) && expN != 0;
      slow <= i[0];
      irqGlobalEn <= r.ge;
      apb(1'b1, `DTX_IDX_IO, io);
      apb(1'b1, `DTX_IDX_HI, {r.endHi, r.st[11:8]});
      apb(1'b1, `DTX_IDX_START, r.st[7:0]);
      apb(1'b1, `DTX_IDX_END, r.endLo);
      apb(1'b1, `DTX_IDX_MASK, {3'h0, r.msk, 4'h0});
      apb(1'b1, `DTX_IDX_CTL, r.ctl);
      base = wrCnt;
      trig <= dtx_trig_s'((r.ctl[2:0] == 3'h7) ? 7'h7f :
        7'h1 << (r.ctl[2] ? 3'h6 - r.ctl[2:0] : r.ctl[2:0] + 3'h3));
      for (int k = 0; k < 100 && wrCnt - base < expN; k++) @(posedge clk_sys);
      repeat (12) @(posedge clk_sys);
      trig <= '0;
      @(posedge clk_sys);
      chk(wrCnt - base, expN);
      if (expN != 0) begin
        chk(lastA, r.ctl[5] ? a : {4'hf, io + 8'(n - 1)});
        chk(lastD, (r.ctl[5] ? io + 8'(n - 1) : a[7:0]) ^ 8'h5a);
      end
      apb(1'b0, `DTX_IDX_START, 8'h00);
      chk(rd, (done || expN == 0) ? r.st[7:0] : a[7:0] + 8'h1);
      apb(1'b0, `DTX_IDX_CTL, 8'h00);
      chk(rd[7], r.ctl[7] && !(done && !r.ctl[6]));
      apb(1'b0, `DTX_IDX_IRQ, 8'h00);
      chk(rd[4], done && r.ctl[4]);
      chk(irq, done && r.ctl[4] && r.ge && r.msk);
      apb(1'b1, `DTX_IDX_IRQ, 8'h10);
    end
    apb(1'b0, 12'h000, 8'h00);
    chk(rd, 32'h0);
    chk(err, 32'h1);
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, `DTX_IDX_CTL, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, `DTX_IDX_IRQ, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, `DTX_IDX_HI, 8'h00);
    chk(rd, 32'h0);
    final_report;
  end
endmodule
`default_nettype wire
